//--- inc/tmz_pkg.sv
// Purpose: constants shared by the timer/counter block
// Assumes: one system clock; instruction cycle is four phase steps
// Notes: the option control register has no bus address of its own
package tmz_pkg;
  localparam logic [7:0] TIMER_COUNT_OFFSET = 8'h01;
  localparam logic [7:0] OPTION_RESET = 8'h3f;
  localparam int CSS_BIT = 5;
  localparam int EDGE_BIT = 4;
  localparam int PSA_BIT = 3;
  localparam int RATE_LSB = 0;
  localparam int INHIBIT_CYCLES = 2;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [1:0] INHIBIT_RESET = 2'h0;
  // Phase sequencer, Gray coded Q1..Q4
  typedef enum logic [1:0]
  {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b11,
    PH_Q4 = 2'b10
  } tmz_phase_t;
endpackage

//--- rtl/tmz_prescaler.sv
// Purpose: 8-bit prescaler shared by timer and watchdog
// Assumes: count_i is a one-cycle pulse per event
// Notes: the count is not visible to software; only the tap is output
`timescale 1ns/1ps
module tmz_prescaler
(
  // Clock, reset and enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic enable_i,
  // Control
  input wire logic clear_i,
  input wire logic count_i,
  input wire logic [3:0] tap_i,
  // Divided output level
  output logic tap_o
);
  // No port exposes the count
  logic [7:0] count_q;
  logic [8:0] chain;

  // =====================================================
  // Divider
  assign chain = {count_q, count_i};

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= tmz_pkg::PRESCALE_RESET;
    else if (enable_i)
    begin
      if (clear_i)
        count_q <= tmz_pkg::PRESCALE_RESET;
      else if (count_i)
        count_q <= count_q + 8'h01;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      tap_o <= 1'b0;
    else if (enable_i)
      tap_o <= chain[tap_i];
  end

  // =====================================================
  // Assertions
  a_clear_zeroes_count: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     enable_i && clear_i |=> count_q == tmz_pkg::PRESCALE_RESET)
    else $error("prescaler clear left a count");

  a_count_steps: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     enable_i && !clear_i && count_i |=> count_q == $past(count_q) + 8'h01)
    else $error("prescaler missed an event");
endmodule

//--- rtl/tmz_timer0.sv
// Purpose: 8-bit timer/counter with prescaler shared with the watchdog
// Assumes: inputs are synchronous to clock_i; write strobes last one cycle
// Notes: a prescaler tap is a level; the synchroniser counts its edges
`timescale 1ns/1ps

module tmz_timer0
(
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Register access
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic option_wr_i,
  // Watchdog side
  input wire logic watchdog_clear_instr_i,
  input wire logic watchdog_tick_i,
  // External count input
  input wire logic external_count_input_i,
  // Outputs
  output logic [7:0] timer_count_o,
  output logic watchdog_tick_o,
  output logic [7:0] option_o
);
  tmz_pkg::tmz_phase_t phase_q;
  logic [7:0] option_q;
  logic [7:0] count_q;
  logic [1:0] inhibit_q;
  logic ext_q;
  logic samp_q;
  logic rise_q;
  logic tap;
  logic tap_prev_q;
  logic watchdog_tick_q;
  logic tmr_wr;
  logic css;
  logic assign_wd;
  logic ext_adj;
  logic ext_rise;
  logic ps_src;
  logic ps_clear;
  logic ps_level;
  logic [3:0] tap_sel;
  logic [2:0] rate;
  logic inc_src;
  logic cycle_end;
  logic sample_phase;
  logic direct_mode;

  // =====================================================
  // Decode
  assign css = option_q[tmz_pkg::CSS_BIT];
  assign assign_wd = option_q[tmz_pkg::PSA_BIT];
  assign rate = option_q[tmz_pkg::RATE_LSB +: 3];
  assign tmr_wr = wr_i && (addr_i == tmz_pkg::TIMER_COUNT_OFFSET);
  assign cycle_end = (phase_q == tmz_pkg::PH_Q4);
  assign sample_phase = (phase_q == tmz_pkg::PH_Q2) ||
                        (phase_q == tmz_pkg::PH_Q4);
  // Timer mode with no prescaler counts instruction cycles directly
  assign direct_mode = !css && assign_wd;

  // =====================================================
  // Phase sequencer
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      phase_q <= tmz_pkg::PH_Q1;
    else if (clk_en_i)
    begin
      case (phase_q)
        tmz_pkg::PH_Q1: phase_q <= tmz_pkg::PH_Q2;
        tmz_pkg::PH_Q2: phase_q <= tmz_pkg::PH_Q3;
        tmz_pkg::PH_Q3: phase_q <= tmz_pkg::PH_Q4;
        tmz_pkg::PH_Q4: phase_q <= tmz_pkg::PH_Q1;
        default: phase_q <= tmz_pkg::PH_Q1;
      endcase
    end
  end

  // =====================================================
  // Option control register
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      option_q <= tmz_pkg::OPTION_RESET;
    else if (clk_en_i && option_wr_i)
      option_q <= {2'b00, wdata_i[5:0]};
  end

  // =====================================================
  // Edge selection
  // Falling edges become rising ones after the inversion
  assign ext_adj = external_count_input_i ^
                   option_q[tmz_pkg::EDGE_BIT];
  assign ext_rise = ext_adj && !ext_q;

  // Reset level matches a low pin under the reset edge choice
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      ext_q <= 1'b1;
    else if (clk_en_i)
      ext_q <= ext_adj;
  end

  // =====================================================
  // Prescaler routing
  always_comb
  begin
    if (assign_wd)
    begin
      ps_src = watchdog_tick_i;
      ps_clear = watchdog_clear_instr_i;
      tap_sel = {1'b0, rate};
    end
    else
    begin
      ps_src = css ? ext_rise : cycle_end;
      ps_clear = tmr_wr;
      tap_sel = {1'b0, rate} + 4'h1;
    end
  end

  tmz_prescaler u_prescaler
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .enable_i(clk_en_i),
    .clear_i(ps_clear),
    .count_i(ps_src),
    .tap_i(tap_sel),
    .tap_o(tap)
  );

  // Only one user sees the prescaler at a time
  assign ps_level = assign_wd ? ext_q : tap;

  // =====================================================
  // Synchroniser
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      samp_q <= 1'b1;
      rise_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (sample_phase)
      begin
        samp_q <= ps_level;
        rise_q <= ps_level && !samp_q;
      end
      else
        rise_q <= 1'b0;
    end
  end

  // =====================================================
  // Write inhibit
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      inhibit_q <= tmz_pkg::INHIBIT_RESET;
    else if (clk_en_i)
    begin
      if (tmr_wr)
        inhibit_q <= 2'(tmz_pkg::INHIBIT_CYCLES);
      else if (cycle_end && inhibit_q != 2'h0)
        inhibit_q <= inhibit_q - 2'h1;
    end
  end

  // =====================================================
  // Counter
  assign inc_src = direct_mode ? cycle_end : rise_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      count_q <= tmz_pkg::COUNT_RESET;
    else if (clk_en_i)
    begin
      if (tmr_wr)
        count_q <= wdata_i;
      else if (inc_src && inhibit_q == 2'h0)
        count_q <= count_q + 8'h01;
    end
  end

  // =====================================================
  // Watchdog tick
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tap_prev_q <= 1'b0;
      watchdog_tick_q <= 1'b0;
    end
    else if (clk_en_i)
    begin
      tap_prev_q <= tap;
      if (assign_wd)
        watchdog_tick_q <= tap && !tap_prev_q;
      else
        watchdog_tick_q <= watchdog_tick_i;
    end
  end

  // =====================================================
  // Outputs
  assign timer_count_o = count_q;
  assign option_o = option_q;
  assign watchdog_tick_o = watchdog_tick_q;

  // =====================================================
  // Assertions
  a_write_loads_count: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     clk_en_i && tmr_wr |=> count_q == $past(wdata_i))
    else $error("count register write not loaded");

  a_inhibit_holds_count: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     clk_en_i && !tmr_wr && inhibit_q != 2'h0 |=> count_q == $past(count_q))
    else $error("count moved during write inhibit");

  a_timer_mode_step: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     clk_en_i && direct_mode && cycle_end && inhibit_q == 2'h0 && !tmr_wr
     |=> count_q == $past(count_q) + 8'h01)
    else $error("timer mode missed an instruction cycle");

  a_counter_waits_sync: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     clk_en_i && css && !tmr_wr && !rise_q |=> count_q == $past(count_q))
    else $error("counter mode moved without a synchronised edge");

  a_sync_on_phase: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     rise_q && $past(clk_en_i) |-> $past(sample_phase))
    else $error("edge taken outside phases two and four");

  a_wd_tick_passes: assert property
    (@(posedge clock_i) disable iff (!rst_n_i)
     clk_en_i && !assign_wd |=> watchdog_tick_q == $past(watchdog_tick_i))
    else $error("watchdog divided while timer owns prescaler");

  c_timer_step: cover property
    (@(posedge clock_i) disable iff (!rst_n_i)
     direct_mode && cycle_end && inhibit_q == 2'h0);

  c_counter_step: cover property
    (@(posedge clock_i) disable iff (!rst_n_i)
     css && rise_q && inhibit_q == 2'h0);

  c_count_wrap: cover property
    (@(posedge clock_i) disable iff (!rst_n_i)
     count_q == 8'hff ##1 count_q == 8'h00);
endmodule

//--- tb/tmz_count_src.sv
// Purpose: external count source facing the timer input pin
// Assumes: levels change only at falling clock edges
// Notes: idles low between bursts
`timescale 1ns/1ps
module tmz_count_src
(
  // Clock
  input wire logic clock_i,
  // Count pin
  output logic ext_o
);
  initial ext_o = 1'b0;
  // Each level held four clocks, longer than the sampling minimum
  task automatic pulse(input int n);
    repeat (n)
    begin
      repeat (4) @(negedge clock_i);
      ext_o = 1'b1;
      repeat (4) @(negedge clock_i);
      ext_o = 1'b0;
    end
  endtask
endmodule

//--- tb/timer0_with_shared_prescaler_tb.sv
// Purpose: self-checking bench for the timer/counter
// Assumes: clk_en_i held high
// Notes: counter mode checked over both edge choices, prescaler bypass and prescaler rates 0 and 1
`timescale 1ns/1ps
module timer0_with_shared_prescaler_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic option_wr_i = 1'b0;
  logic wd_clr = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic [7:0] timer_count_o;
  logic [7:0] option_o;
  logic [7:0] opt_t [4] = '{8'h38, 8'h28, 8'h20, 8'h21};
  logic [15:0] exp_q [$];
  logic [15:0] e;
  logic [7:0] d;
  wire ext;
  int num_errors = 0;
  int total_checks = 0;
  int k;
  event take;
  always #4 clock_i = ~clock_i;
  tmz_count_src src (.clock_i(clock_i), .ext_o(ext));
  tmz_timer0 dut
  (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .clk_en_i(1'b1),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .option_wr_i(option_wr_i), .watchdog_clear_instr_i(wd_clr),
    .watchdog_tick_i(1'b0), .external_count_input_i(ext),
    .timer_count_o(timer_count_o), .watchdog_tick_o(),
    .option_o(option_o)
  );
  task stop_test;
    $display("errors %0d checks %0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task wr(input logic [7:0] v, input logic opt);
    @(negedge clock_i);
    addr_i = tmz_pkg::TIMER_COUNT_OFFSET;
    wdata_i = v;
    wr_i = ~opt;
    option_wr_i = opt;
    @(negedge clock_i);
    wr_i = 1'b0;
    option_wr_i = 1'b0;
  endtask
  task clr_wd;
    @(negedge clock_i);
    wd_clr = 1'b1;
    @(negedge clock_i);
    wd_clr = 1'b0;
  endtask
  always @(take)
  begin
    e = exp_q.pop_front();
    total_checks++;
    if (e !== {option_o, timer_count_o})
    begin
      num_errors++;
      $display("Error %0t exp %h got %h", $time, e, {option_o, timer_count_o});
    end
  end
  initial
  begin
    k = $urandom(32'h0f9b);
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    rst_n_i = 1'b1;
    exp_q.push_back({tmz_pkg::OPTION_RESET, tmz_pkg::COUNT_RESET});
    ->take;
    foreach (opt_t[i])
    begin
      k = $urandom_range(1, 9);
      d = $urandom;
      clr_wd();
      wr(opt_t[i], 1'b1);
      wr(d, 1'b0);
      repeat (16) @(negedge clock_i);
      src.pulse(k * (opt_t[i][3] ? 1 : (2 << opt_t[i][2:0])));
      repeat (16) @(negedge clock_i);
      exp_q.push_back({opt_t[i], d + k[7:0]});
      ->take;
    end
    clr_wd();
    wr(8'h00, 1'b0);
    wr(8'h08, 1'b1);
    d = $urandom;
    k = $urandom_range(2, 40);
    wr(d, 1'b0);
    repeat (4 * k) @(negedge clock_i);
    exp_q.push_back({8'h08, d + k[7:0] - 8'h02});
    ->take;
    #8;
    stop_test;
  end
  initial
  begin
    #200000;
    num_errors++;
    stop_test;
  end
endmodule
